//--- hw/occ_cache.sv
// four-way unified cache, burst line fill, snoop invalidate, write-through
// assumes core holds its request until cpuRdy and memory acks each beat
`timescale 1ns/1ps
module occ_cache
   import occ_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cpuReq,
   input wire logic cpuWe,
   input wire logic [ADDR_W-1:0] cpuAddr,
   input wire logic [DATA_W-1:0] cpuWdata,
   output logic cpuRdy_ff,
   output logic [DATA_W-1:0] cpuRdata_ff,
   output logic [LINE_W-1:0] cpuLine_ff,
   output logic busReq_ff,
   output logic busWe_ff,
   output logic busBurst_ff,
   output logic [ADDR_W-1:0] busAddr_ff,
   output logic [DATA_W-1:0] busWdata_ff,
   input wire logic busAck,
   input wire logic [DATA_W-1:0] busRdata,
   input wire logic snpValid,
   input wire logic [ADDR_W-1:0] snpAddr
);
   logic [LINE_W-1:0] dataArr [NWAY][NSET];
   logic [TAG_W-1:0] tagArr [NWAY][NSET];
   logic [NWAY-1:0] validArr [NSET];
   logic [2:0] plruArr [NSET];
   occ_state_t state_ff;
   logic [1:0] beat_ff;
   logic [LINE_W-1:0] fillLine_ff;
   logic [ADDR_W-OFF_W-1:0] fillAddr_ff;
   logic [1:0] fillWay_ff;
   logic fillKill_ff;
   logic missPend_ff;
   logic [SET_W-1:0] cpuSet;
   logic [SET_W-1:0] snpSet;
   logic [SET_W-1:0] fillSet;
   logic [NWAY-1:0] hitVec;
   logic [NWAY-1:0] snpVec;
   logic [1:0] hitWay;
   logic [1:0] victim;
   logic hit;
   logic take;
   logic readHit;
   logic fillStart;
   logic wrReq;
   logic writeTake;
   logic writeHit;
   logic firstBeat;
   logic fillDone;
   logic moreWrite;
   logic wbPushReady;
   logic wbPopValid;
   logic wbPopReady;
   occ_wb_entry_t wbHead;
   logic [2:0] wbCount;

   function automatic logic [1:0] enc4(input logic [3:0] v);
      return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
   endfunction : enc4

   function automatic logic [DATA_W-1:0] wordOf(input logic [LINE_W-1:0] l,
                                                  input logic [1:0] i);
      return l[DATA_W*i +: DATA_W];
   endfunction : wordOf

   function automatic logic [LINE_W-1:0] putWord(input logic [LINE_W-1:0] l,
                                                   input logic [1:0] i,
                                                   input logic [DATA_W-1:0] w);
      logic [LINE_W-1:0] r;
      r = l;
      r[DATA_W*i +: DATA_W] = w;
      return r;
   endfunction : putWord

   // tree bits point at the victim; touching a way points them away
   function automatic logic [2:0] plruTouch(input logic [2:0] b, input logic [1:0] w);
      logic [2:0] r;
      r = b;
      r[0] = ~w[1];
      if (w[1]) r[2] = ~w[0];
      else r[1] = ~w[0];
      return r;
   endfunction : plruTouch

   // set index lies below the page offset so lookup needs no translated bits
   assign cpuSet = cpuAddr[OFF_W +: SET_W]; // [R11]
   assign snpSet = snpAddr[OFF_W +: SET_W];
   assign fillSet = fillAddr_ff[SET_W-1:0];

   always_comb begin
      for (int w = 0; w < NWAY; w++) begin
         hitVec[w] = validArr[cpuSet][w] && tagArr[w][cpuSet] == cpuAddr[ADDR_W-1 -: TAG_W];
         snpVec[w] = validArr[snpSet][w] && tagArr[w][snpSet] == snpAddr[ADDR_W-1 -: TAG_W];
      end
   end

   assign hit = |hitVec;
   assign hitWay = enc4(hitVec);
   // free way first, else tree victim
   assign victim = !validArr[cpuSet][0] ? 2'h0 : !validArr[cpuSet][1] ? 2'h1 :
                   !validArr[cpuSet][2] ? 2'h2 : !validArr[cpuSet][3] ? 2'h3 :
                   plruArr[cpuSet][0] ? {1'b1, plruArr[cpuSet][2]} :
                   {1'b0, plruArr[cpuSet][1]}; // [R12]

   assign take = cpuReq && !cpuRdy_ff && !missPend_ff;
   assign readHit = take && !cpuWe && hit; // [R5]
   assign fillStart = take && !cpuWe && !hit && state_ff == ST_IDLE && !wbPopValid; // [R3]
   assign wrReq = take && cpuWe && state_ff != ST_FILL;
   assign writeTake = wrReq && wbPushReady; // [R8]
   assign writeHit = writeTake && hit; // [R10]
   assign firstBeat = state_ff == ST_FILL && busAck && beat_ff == 2'h0;
   assign fillDone = state_ff == ST_FILL && busAck && beat_ff == BEAT_LAST;
   assign moreWrite = busBurst_ff && beat_ff != BEAT_LAST && wbPopValid; // [R9]
   assign wbPopReady = (state_ff == ST_IDLE && !fillStart) ||
                       (state_ff == ST_WRITE && busAck && moreWrite);

   occ_wbuf u_occ_wbuf (
      .clk(clk),
      .sys_rst(sys_rst),
      .pushValid(wrReq),
      .pushEntry({cpuAddr, cpuWdata}),
      .pushReady(wbPushReady),
      .popValid(wbPopValid),
      .popEntry(wbHead),
      .popReady(wbPopReady),
      .count(wbCount)
   );

   // external bus sequencing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         busReq_ff <= 1'b0;
         busWe_ff <= 1'b0;
         busBurst_ff <= 1'b0;
         busAddr_ff <= '0;
         busWdata_ff <= '0;
         beat_ff <= 2'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               beat_ff <= 2'h0;
               if (fillStart) begin
                  state_ff <= ST_FILL;
                  busReq_ff <= 1'b1;
                  busWe_ff <= 1'b0;
                  busBurst_ff <= 1'b1; // [R3]
                  busAddr_ff <= {cpuAddr[ADDR_W-1:2], 2'h0}; // [R4]
               end else if (wbPopValid) begin
                  state_ff <= ST_WRITE;
                  busReq_ff <= 1'b1; // [R8]
                  busWe_ff <= 1'b1;
                  busBurst_ff <= (wbCount == WB_FULL); // [R9]
                  busAddr_ff <= wbHead.addr;
                  busWdata_ff <= wbHead.data;
               end
            end
            ST_FILL: begin
               if (busAck) begin
                  beat_ff <= beat_ff + 2'h1;
                  busAddr_ff[3:2] <= busAddr_ff[3:2] + 2'h1; // [R3]
                  if (beat_ff == BEAT_LAST) begin
                     state_ff <= ST_IDLE;
                     busReq_ff <= 1'b0;
                     busBurst_ff <= 1'b0;
                  end
               end
            end
            ST_WRITE: begin
               if (busAck) begin
                  beat_ff <= beat_ff + 2'h1;
                  if (moreWrite) begin
                     busAddr_ff <= wbHead.addr; // [R9]
                     busWdata_ff <= wbHead.data;
                  end else begin
                     state_ff <= ST_IDLE;
                     busReq_ff <= 1'b0;
                     busWe_ff <= 1'b0;
                     busBurst_ff <= 1'b0;
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // line fill collection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fillLine_ff <= '0;
         fillAddr_ff <= '0;
         fillWay_ff <= 2'h0;
         fillKill_ff <= 1'b0;
      end else begin
         if (fillStart) begin
            fillAddr_ff <= cpuAddr[ADDR_W-1:OFF_W];
            fillWay_ff <= victim;
            fillKill_ff <= 1'b0;
         end
         if (state_ff == ST_FILL && busAck) begin
            fillLine_ff <= putWord(fillLine_ff, busAddr_ff[3:2], busRdata);
         end
         if (state_ff == ST_FILL && snpValid && snpAddr[ADDR_W-1:OFF_W] == fillAddr_ff) begin
            fillKill_ff <= 1'b1; // [R13]
         end
      end
   end

   // core answers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpuRdy_ff <= 1'b0;
         cpuRdata_ff <= '0;
         cpuLine_ff <= '0;
         missPend_ff <= 1'b0;
      end else begin
         cpuRdy_ff <= readHit || writeTake || firstBeat; // [R10]
         if (readHit) begin
            cpuLine_ff <= dataArr[hitWay][cpuSet]; // [R6]
            cpuRdata_ff <= wordOf(dataArr[hitWay][cpuSet], cpuAddr[3:2]);
         end else if (firstBeat) begin
            cpuRdata_ff <= busRdata; // [R4]
         end
         if (fillStart) missPend_ff <= 1'b1;
         else if (firstBeat) missPend_ff <= 1'b0; // [R4]
      end
   end

   // data and tag arrays
   always_ff @(posedge clk) begin
      if (fillDone) begin
         dataArr[fillWay_ff][fillSet] <= putWord(fillLine_ff, busAddr_ff[3:2], busRdata);
         tagArr[fillWay_ff][fillSet] <= fillAddr_ff[ADDR_W-OFF_W-1 -: TAG_W];
      end else if (writeHit) begin
         dataArr[hitWay][cpuSet] <= putWord(dataArr[hitWay][cpuSet], cpuAddr[3:2],
                                            cpuWdata); // [R10]
      end
   end

   // valid bits; snoop clears win over fill completion
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int s = 0; s < NSET; s++) validArr[s] <= '0;
      end else begin
         if (fillStart) validArr[cpuSet][victim] <= 1'b0;
         if (fillDone) validArr[fillSet][fillWay_ff] <= !fillKill_ff && !(snpValid &&
            snpAddr[ADDR_W-1:OFF_W] == fillAddr_ff); // [R13]
         for (int w = 0; w < NWAY; w++) begin
            if (snpValid && snpVec[w]) validArr[snpSet][w] <= 1'b0; // [R2]
         end
      end
   end

   // replacement state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int s = 0; s < NSET; s++) plruArr[s] <= 3'h0;
      end else if (fillDone) begin
         plruArr[fillSet] <= plruTouch(plruArr[fillSet], fillWay_ff); // [R12]
      end else if (readHit || writeHit) begin
         plruArr[cpuSet] <= plruTouch(plruArr[cpuSet], hitWay); // [R12]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_hit;
      readHit |=> cpuRdy_ff && cpuRdata_ff == wordOf(cpuLine_ff, $past(cpuAddr[3:2]));
   endproperty
   a_hit: assert property (p_hit) else $error("hit not answered next cycle"); // [R5]

   property p_hit_quiet;
      readHit && state_ff == ST_IDLE && !wbPopValid |=> !busReq_ff;
   endproperty
   a_hit_quiet: assert property (p_hit_quiet) else $error("hit used the bus"); // [R5]

   sequence s_fill_go;
      busReq_ff && !busWe_ff && busBurst_ff && state_ff == ST_FILL;
   endsequence
   property p_fill_start;
      fillStart |=> s_fill_go;
   endproperty
   a_fill_start: assert property (p_fill_start) else $error("miss without burst read"); // [R3]

   property p_fill_len;
      fillStart ##1 busAck [*4] |=> state_ff == ST_IDLE && !busReq_ff;
   endproperty
   a_fill_len: assert property (p_fill_len) else $error("fill not four beats"); // [R3]

   property p_first_word;
      firstBeat |=> cpuRdy_ff && cpuRdata_ff == $past(busRdata) && state_ff == ST_FILL;
   endproperty
   a_first_word: assert property (p_first_word) else $error("requested word late"); // [R4]

   property p_snoop;
      snpValid && |snpVec |=> !validArr[$past(snpSet)][$past(enc4(snpVec))];
   endproperty
   a_snoop: assert property (p_snoop) else $error("snooped line still valid"); // [R2]

   property p_kill;
      fillDone && fillKill_ff |=> !validArr[$past(fillSet)][$past(fillWay_ff)];
   endproperty
   a_kill: assert property (p_kill) else $error("snooped fill left valid"); // [R13]

   property p_drain;
      state_ff == ST_IDLE && wbPopValid && !fillStart |=> busReq_ff && busWe_ff;
   endproperty
   a_drain: assert property (p_drain) else $error("idle bus not draining"); // [R8]

   property p_burst_wr;
      state_ff == ST_IDLE && wbCount == WB_FULL |=> busBurst_ff && busWe_ff;
   endproperty
   a_burst_wr: assert property (p_burst_wr) else $error("full buffer not burst"); // [R9]

   property p_write;
      writeTake |=> cpuRdy_ff;
   endproperty
   a_write: assert property (p_write) else $error("write stalled core"); // [R10]

   property p_page;
      OFF_W + SET_W <= PAGE_W;
   endproperty
   a_page: assert property (p_page) else $error("index crosses page"); // [R11]
endmodule : occ_cache

//--- common/occ_pkg.sv
// constants and types of the on-chip cache with write buffer
// assumes one clock and a synchronous active-high reset in every user
// Operation
// [R1] eight kilobytes, four ways, sixteen-byte lines
// [R2] a write by another bus master invalidates any cached copy
// [R3] read miss fetches the line as a four-beat burst, one beat per cycle
// [R4] requested word goes to the core first, rest of line loads behind
// [R5] a hit answers in one cycle and leaves the external bus alone
// [R6] cache to core path is 128 bits wide
// [R7] external side has 32-bit data and 32-bit address
// [R8] processor writes enter a four-entry buffer, drained when bus idle
// [R9] a full write buffer drains as a burst write
// [R10] a write updates the cached copy at once, core does not wait; the code holds the write while the buffer is full or a line fill runs
// [R11] translation pages are four kilobytes; set index stays inside a page
// [R12] victim chosen by pseudo least-recently-used over four ways
// [R13] a line snooped while filling ends the fill invalid
package occ_pkg;
   localparam int ADDR_W = 32; // [R7]
   localparam int DATA_W = 32; // [R7]
   localparam int LINE_W = 128; // [R6]
   localparam int CACHE_BYTES = 8192; // [R1]
   localparam int LINE_BYTES = 16; // [R1]
   localparam int NWAY = 4; // [R1]
   localparam int NSET = CACHE_BYTES / (LINE_BYTES * NWAY);
   localparam int OFF_W = 4;
   localparam int SET_W = 7;
   localparam int TAG_W = ADDR_W - OFF_W - SET_W;
   localparam int PAGE_BYTES = 4096; // [R11]
   localparam int PAGE_W = 12; // [R11]
   localparam int WB_DEPTH = 4; // [R8]
   localparam logic [2:0] WB_FULL = 3'h4; // [R9]
   localparam logic [1:0] BEAT_LAST = 2'h3; // [R3]
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_FILL = 2'h1,
      ST_WRITE = 2'h2
   } occ_state_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } occ_wb_entry_t;
endpackage : occ_pkg

//--- hw/occ_wbuf.sv
// four-entry write buffer between core writes and the external bus
// assumes the bus controller pops the head only while it can issue it
`timescale 1ns/1ps
module occ_wbuf
   import occ_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pushValid,
   input wire occ_wb_entry_t pushEntry,
   output logic pushReady,
   output logic popValid,
   output occ_wb_entry_t popEntry,
   input wire logic popReady,
   output logic [2:0] count
);
   occ_wb_entry_t mem [WB_DEPTH];
   logic [1:0] wrPtr_ff;
   logic [1:0] rdPtr_ff;
   logic [2:0] cnt_ff;
   logic doPush;
   logic doPop;

   assign pushReady = (cnt_ff != WB_FULL);
   assign popValid = (cnt_ff != 3'h0);
   assign popEntry = mem[rdPtr_ff];
   assign count = cnt_ff;
   assign doPush = pushValid && pushReady;
   assign doPop = popValid && popReady;

   // storage
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_ff] <= pushEntry; // [R8]
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr_ff <= 2'h0;
         rdPtr_ff <= 2'h0;
         cnt_ff <= 3'h0;
      end else begin
         if (doPush) wrPtr_ff <= wrPtr_ff + 2'h1;
         if (doPop) rdPtr_ff <= rdPtr_ff + 2'h1;
         cnt_ff <= cnt_ff + {2'h0, doPush} - {2'h0, doPop}; // [R8]
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_wb_bound;
      cnt_ff <= WB_FULL;
   endproperty
   a_wb_bound: assert property (p_wb_bound) else $error("write buffer overflow"); // [R8]

   property p_wb_count;
      doPush && !doPop |=> cnt_ff == $past(cnt_ff) + 3'h1;
   endproperty
   a_wb_count: assert property (p_wb_count) else $error("write buffer lost a push"); // [R8]
endmodule : occ_wbuf

//--- verif/occ_mem_model.sv
// memory partner on the external bus: one beat per cycle once started
// assumes bus outputs of the cache change only at rising edges
`timescale 1ns/1ps
module occ_mem_model
   import occ_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic busReq,
   input wire logic busWe,
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic [DATA_W-1:0] busWdata,
   input wire logic [3:0] waitCycles,
   output logic busAck,
   output logic [DATA_W-1:0] busRdata
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   int waited = 0;
   initial busAck = 1'b0;
   initial busRdata = 32'h0;
   // released bus toggles so no stale word looks valid
   always @(negedge clk) begin
      if (sys_rst || !busReq) begin
         busAck = 1'b0;
         waited = 0;
         busRdata = ~busRdata;
      end else if (waited < int'(waitCycles)) begin
         waited++;
         busAck = 1'b0;
         busRdata = ~busRdata;
      end else begin
         busAck = 1'b1;
         if (mem.exists({busAddr[31:2], 2'h0})) begin
            busRdata = mem[{busAddr[31:2], 2'h0}];
         end else begin
            busRdata = {~busAddr[15:0], busAddr[15:0]};
         end
      end
   end
   always @(posedge clk) begin
      if (busReq && busAck && busWe) begin
         mem[{busAddr[31:2], 2'h0}] = busWdata;
      end
   end
endmodule : occ_mem_model

//--- verif/occ_cache_bench.sv
// self-checking bench of the cache with a memory partner
// assumes occ_mem_model answers the external bus
`timescale 1ns/1ps
module occ_cache_bench
   import occ_pkg::*;
();
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cpuReq = 1'b0;
   logic cpuWe = 1'b0;
   logic snpValid = 1'b0;
   logic [31:0] cpuAddr = 32'h0;
   logic [31:0] cpuWdata = 32'h0;
   logic [31:0] snpAddr = 32'h0;
   logic [3:0] waitCycles = 4'h0;
   logic cpuRdy_ff, busReq_ff, busWe_ff, busBurst_ff, busAck;
   logic [31:0] cpuRdata_ff, busAddr_ff, busWdata_ff, busRdata, gotWord;
   logic [127:0] cpuLine_ff, gotLine;
   logic [31:0] rdAddr [4];
   int errCount = 0;
   int checksDone = 0;
   int rdBeats = 0;
   int wrBeats = 0;
   int burstBeats = 0;
   int lat = 0;
   always #2 clk = ~clk;
   occ_cache u_occ_cache (.clk(clk), .sys_rst(sys_rst), .cpuReq(cpuReq), .cpuWe(cpuWe),
      .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdy_ff(cpuRdy_ff),
      .cpuRdata_ff(cpuRdata_ff), .cpuLine_ff(cpuLine_ff), .busReq_ff(busReq_ff),
      .busWe_ff(busWe_ff), .busBurst_ff(busBurst_ff), .busAddr_ff(busAddr_ff),
      .busWdata_ff(busWdata_ff), .busAck(busAck), .busRdata(busRdata),
      .snpValid(snpValid), .snpAddr(snpAddr));
   occ_mem_model u_occ_mem_model (.clk(clk), .sys_rst(sys_rst), .busReq(busReq_ff),
      .busWe(busWe_ff), .busAddr(busAddr_ff), .busWdata(busWdata_ff),
      .waitCycles(waitCycles), .busAck(busAck), .busRdata(busRdata));
   // bus beat monitor
   always @(posedge clk) begin
      if (busReq_ff && busAck) begin
         if (busWe_ff) begin
            wrBeats++;
            if (busBurst_ff) burstBeats++;
         end else begin
            rdAddr[rdBeats % 4] = busAddr_ff;
            rdBeats++;
         end
      end
   end
   function automatic logic [31:0] ex(input logic [31:0] a);
      return {~a[15:0], a[15:0]};
   endfunction : ex
   task automatic check(input logic ok, input string msg);
      checksDone++;
      if (ok !== 1'b1) begin
         errCount++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d);
      @(negedge clk);
      cpuReq = 1'b1;
      cpuWe = we;
      cpuAddr = a;
      cpuWdata = d;
      lat = 0;
      do begin
         @(posedge clk);
         #1;
         lat++;
      end while (cpuRdy_ff !== 1'b1 && lat < 60);
      gotWord = cpuRdata_ff;
      gotLine = cpuLine_ff;
      check(cpuRdy_ff === 1'b1, "no answer to core");
      @(negedge clk);
      cpuReq = 1'b0;
   endtask : access
   task automatic settle();
      int quiet;
      int n;
      quiet = 0;
      n = 0;
      while (quiet < 3 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
         quiet = (busReq_ff === 1'b0) ? quiet + 1 : 0;
      end
   endtask : settle
   task automatic snoop(input logic [31:0] a, input logic [31:0] d);
      u_occ_mem_model.mem[a] = d;
      @(negedge clk);
      snpValid = 1'b1;
      snpAddr = a;
      @(negedge clk);
      snpValid = 1'b0;
   endtask : snoop
   task automatic tMissHit();
      int r0;
      r0 = rdBeats;
      access(1'b0, 32'h8000_1008, 32'h0);
      check(gotWord === ex(32'h8000_1008), "critical word");
      check(lat >= 2 && lat <= 3 && rdBeats - r0 < 4, "core held for line");
      settle();
      check(rdBeats - r0 == 4, "fill beat count");
      for (int i = 0; i < 4; i++) begin
         check(rdAddr[(r0 + i) % 4] === 32'h8000_1000 + 32'((2 + i) % 4 * 4), "wrap");
      end
      access(1'b0, 32'h8000_1000, 32'h0);
      check(lat == 1 && rdBeats - r0 == 4, "hit timing");
      check(gotLine === {ex(32'h8000_100C), ex(32'h8000_1008), ex(32'h8000_1004),
         ex(32'h8000_1000)}, "line");
      $display("test miss and hit done");
   endtask : tMissHit
   task automatic tWrite();
      int w0;
      w0 = wrBeats;
      access(1'b1, 32'h8000_1004, 32'hA5A5_5A5A);
      check(lat == 1, "write stalled");
      access(1'b0, 32'h8000_1004, 32'h0);
      check(lat == 1 && gotWord === 32'hA5A5_5A5A, "cached copy");
      settle();
      check(wrBeats - w0 == 1, "write beats");
      check(u_occ_mem_model.mem[32'h8000_1004] === 32'hA5A5_5A5A, "memory");
      $display("test write done");
   endtask : tWrite
   task automatic tBurst();
      int w0;
      int b0;
      int worst;
      w0 = wrBeats;
      b0 = burstBeats;
      worst = 0;
      waitCycles = 4'hC;
      for (int i = 0; i < 6; i++) begin
         access(1'b1, 32'h2000 + 32'(i * 16), 32'hB000_0000 + 32'(i));
         if (lat > worst) worst = lat;
      end
      check(worst > 1, "full buffer took write");
      settle();
      waitCycles = 4'h0;
      check(wrBeats - w0 == 6, "drained writes");
      check(burstBeats - b0 > 0, "no burst drain");
      access(1'b0, 32'h2000, 32'h0);
      check(gotWord === 32'hB000_0000, "read after writes");
      $display("test write burst done");
   endtask : tBurst
   task automatic tSnoop();
      int r0;
      settle();
      snoop(32'h8000_1008, 32'h5EED_0001);
      r0 = rdBeats;
      access(1'b0, 32'h8000_1008, 32'h0);
      settle();
      check(rdBeats - r0 == 4 && gotWord === 32'h5EED_0001, "snoop refetch");
      fork
         access(1'b0, 32'h3000, 32'h0);
         begin
            repeat (2) @(negedge clk);
            snoop(32'h3008, 32'h5EED_0002);
         end
      join
      settle();
      r0 = rdBeats;
      access(1'b0, 32'h3008, 32'h0);
      settle();
      check(rdBeats - r0 == 4 && gotWord === 32'h5EED_0002, "stale fill");
      $display("test snoop done");
   endtask : tSnoop
   task automatic tReplace();
      int r0;
      for (int i = 0; i < 4; i++) access(1'b0, 32'h4050 + 32'(i * 2048), 32'h0);
      settle();
      r0 = rdBeats;
      for (int i = 0; i < 4; i++) access(1'b0, 32'h4050 + 32'(i * 2048), 32'h0);
      access(1'b0, 32'h4050, 32'h0);
      check(rdBeats == r0, "four ways");
      access(1'b0, 32'h6050, 32'h0);
      settle();
      r0 = rdBeats;
      access(1'b0, 32'h4050, 32'h0);
      access(1'b0, 32'h5850, 32'h0);
      check(rdBeats == r0 && gotWord === ex(32'h5850), "recent line evicted");
      $display("test replacement done");
   endtask : tReplace
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5) @(posedge clk);
      #1;
      check(busReq_ff === 1'b0 && cpuRdy_ff === 1'b0, "reset outputs");
      @(negedge clk);
      sys_rst = 1'b0;
      tMissHit();
      tWrite();
      tBurst();
      tSnoop();
      tReplace();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errCount++;
      $display("ERROR at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule : occ_cache_bench
